// ===== design/t1tx_pkg.sv
// constants shared by the t1 transmit interface configuration block
// assumes a single 125 MHz clock and byte-wide register port
package t1tx_pkg;

  // register offsets
  localparam logic [7:0] T1TX_OFF_LINE = 8'h04;
  localparam logic [7:0] T1TX_OFF_BP   = 8'h05;
  localparam logic [7:0] T1TX_OFF_FRM  = 8'h06;

  // transmit_line_format_config fields
  localparam int T1TX_LB_FIFO_BYP = 7;
  localparam int T1TX_LB_AIS_EN   = 6;
  localparam int T1TX_LB_NEG_INV  = 5;
  localparam int T1TX_LB_POS_INV  = 4;
  localparam int T1TX_LB_UNI      = 3;
  localparam int T1TX_LB_FLAG_POL = 2;
  localparam int T1TX_LB_RISE     = 1;
  localparam int T1TX_LB_RZ       = 0;

  // transmit_backplane_config fields
  localparam int T1TX_BB_TWO_BIT  = 4;
  localparam int T1TX_BB_REC_CLK  = 3;
  localparam int T1TX_BB_WIDE     = 2;
  localparam int T1TX_BB_DUAL     = 1;
  localparam int T1TX_BB_SFP      = 0;

  // transmit_framing_passthrough_config fields
  localparam int T1TX_FB_AL_EN    = 5;
  localparam int T1TX_FB_AL_LOC   = 4;
  localparam int T1TX_FB_FRAMING_DISABLE     = 3;
  localparam int T1TX_FB_FBYP     = 2;
  localparam int T1TX_FB_CRC_BIT_PASSTHROUGH   = 1;
  localparam int T1TX_FB_DLBYP    = 0;

  // register widths and reset values
  localparam int T1TX_BP_W  = 5;
  localparam int T1TX_FRM_W = 6;
  localparam logic [7:0]          T1TX_LINE_RST = 8'h00;
  localparam logic [T1TX_BP_W-1:0]  T1TX_BP_RST  = 5'h00;
  localparam logic [T1TX_FRM_W-1:0] T1TX_FRM_RST = 6'h00;
  localparam logic [7:0]          T1TX_UNUSED_RD = 8'h00;

  // jitter fifo geometry and level flag margin
  localparam int T1TX_DEPTH = 32;
  localparam int T1TX_AW    = 5;
  localparam logic [T1TX_AW:0] T1TX_NEAR_FULL  = 6'h1c;
  localparam logic [T1TX_AW:0] T1TX_NEAR_EMPTY = 6'h04;
  localparam logic [T1TX_AW:0] T1TX_FULL       = 6'h20;

  // backplane frame geometry
  localparam logic [8:0] T1TX_T1_LAST   = 9'h0c0; // 193 bit positions
  localparam logic [8:0] T1TX_WIDE_LAST = 9'h0ff; // 256 bit positions
  localparam logic [8:0] T1TX_FBIT_POS  = 9'h0c0; // framing bit slot
  localparam int T1TX_GRP_MSB  = 4;  // 32-bit group: filler + 3 channels
  localparam int T1TX_BYTE_LSB = 3;
  localparam logic [1:0] T1TX_FILLER_BYTE = 2'h0;
  localparam logic [4:0] T1TX_SF_LAST = 5'h17; // 24 frames max

  // kind of framing bit offered by the generator
  localparam logic [1:0] T1TX_FK_FRAME = 2'h0;
  localparam logic [1:0] T1TX_FK_CRC   = 2'h1;
  localparam logic [1:0] T1TX_FK_DL    = 2'h2;

  // alarm changeover states
  typedef enum logic [2:0] {
    T1TX_NORMAL = 3'b001,
    T1TX_AIS    = 3'b010,
    T1TX_EXIT   = 3'b100
  } t1tx_ais_t;

endpackage

// ===== design/t1tx_iface.sv
// t1 transmit interface: config registers, line output stage, jitter
// fifo, backplane frame timing and framing-bit passthrough.
// assumes all clocks from the line and backplane are sampled levels,
// synchronous to i_clk and much slower than it.
// Operation
// - bypass set routes bipolar data around jitter fifo, else through it
// - alarm enable sends all-ones: alternating pulses, or unipolar one
// - alarm entry and exit create no bipolar violation
// - invert bits flip positive and negative outputs
// - unipolar select gives data plus fifo flag, else bipolar pulses
// - unipolar mode marks analog line outputs unusable
// - flag polarity selects within four of full, else of empty
// - outputs update on rising edge if selected, else falling
// - return-to-zero gives half-period bipolar pulses, else full-period nrz
// - reset clears line format register
// - two-bit signalling takes a and b only, else four bits
// - framer clock is recovered clock, else backplane or gapped clock
// - wide rate: filler byte then three channel bytes, eight times
// - narrow rate: 24 channel bytes then one framing bit
// - dual rail inputs skip framer and feed jitter fifo
// - frame pulse marks superframe start, else every framing bit
// - reset clears backplane options register
// - aligner location before framer or after extractor, when enabled
// - framing disable passes data unchanged
// - passthrough bits reinsert backplane framing bits
`timescale 1ns/1ps

module t1tx_iface
  import t1tx_pkg::*;
(
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  input  wire logic       i_ce,
  input  wire logic [7:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  output logic      [7:0] o_rdata,
  input  wire logic       i_line_clk,
  input  wire logic       i_enc_stb,
  input  wire logic       i_enc_pos,
  input  wire logic       i_enc_neg,
  input  wire logic       i_bp_clk,
  input  wire logic       i_rec_clk,
  input  wire logic       i_bp_frame_pulse,
  input  wire logic       i_bp_pcm,
  input  wire logic       i_bp_sig,
  input  wire logic [3:0] i_sig_nibble,
  input  wire logic       i_gen_fbit,
  input  wire logic [1:0] i_fbit_kind,
  output logic            o_tx_pos,
  output logic            o_tx_neg,
  output logic            o_analog_enable,
  output logic            o_framer_clk,
  output logic            o_framer_bit,
  output logic            o_fbit_slot,
  output logic            o_filler_slot,
  output logic      [4:0] o_frame_index,
  output logic      [3:0] o_sig_bits,
  output logic            o_aligner_pre_framer,
  output logic            o_aligner_post_extract
);

  typedef struct packed {
    logic [7:0]                  line_cfg;
    logic [T1TX_BP_W-1:0]        bp_cfg;
    logic [T1TX_FRM_W-1:0]       frm_cfg;
    logic [7:0]                  rdata;
    logic                        line_clk;
    logic                        bp_clk;
    logic [T1TX_DEPTH-1:0][1:0]  mem;
    logic [T1TX_AW-1:0]          wptr;
    logic [T1TX_AW-1:0]          rptr;
    logic [T1TX_AW:0]            count;
    t1tx_ais_t                   ais;
    logic                        last_neg;
    logic                        pos;
    logic                        neg;
    logic                        analog_en;
    logic                        flag;
    logic [8:0]                  bit_pos;
    logic [4:0]                  frame_idx;
    logic                        framer_clk;
    logic                        framer_bit;
    logic                        fbit_slot;
    logic                        filler;
    logic [3:0]                  sig;
    logic                        al_pre;
    logic                        al_post;
  } t1tx_state_t;

  t1tx_state_t q;
  t1tx_state_t d;

  //////////////////////////////////////////////////////////////////////////
  // decoded controls and clock edges

  logic line_rise;
  logic line_fall;
  logic upd;
  logic clr;
  logic bp_rise;
  logic wide;
  logic dual;
  logic bypass;
  logic uni;
  logic ais_en;

  assign line_rise = i_line_clk & ~q.line_clk;
  assign line_fall = ~i_line_clk & q.line_clk;
  assign bp_rise   = i_bp_clk & ~q.bp_clk;
  assign wide      = q.bp_cfg[T1TX_BB_WIDE];
  assign dual      = q.bp_cfg[T1TX_BB_DUAL];
  assign bypass    = q.line_cfg[T1TX_LB_FIFO_BYP];
  assign uni       = q.line_cfg[T1TX_LB_UNI];
  assign ais_en    = q.line_cfg[T1TX_LB_AIS_EN];
  // update edge and the opposite edge that ends an rz pulse
  assign upd = q.line_cfg[T1TX_LB_RISE] ? line_rise : line_fall;
  assign clr = q.line_cfg[T1TX_LB_RISE] ? line_fall : line_rise;

  // passthrough test for the framing bit kind offered this slot
  function automatic logic fbit_pass(input logic [1:0] kind,
                                     input logic [T1TX_FRM_W-1:0] cfg);
    logic r;
    r = 1'b0;
    if (kind == T1TX_FK_FRAME) begin
      r = cfg[T1TX_FB_FBYP];
    end else if (kind == T1TX_FK_CRC) begin
      r = cfg[T1TX_FB_CRC_BIT_PASSTHROUGH];
    end else if (kind == T1TX_FK_DL) begin
      r = cfg[T1TX_FB_DLBYP];
    end
    return r;
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    logic       wr_en;
    logic [1:0] wr_bits;
    logic       rd_en;
    logic [1:0] src;
    logic       mark;
    logic       send_ais;
    logic       p_raw;
    logic       n_raw;
    logic [8:0] np;
    logic [8:0] last;
    wr_en    = 1'b0;
    wr_bits  = 2'h0;
    rd_en    = 1'b0;
    src      = 2'h0;
    mark     = 1'b0;
    send_ais = 1'b0;
    p_raw    = 1'b0;
    n_raw    = 1'b0;
    np       = q.bit_pos;
    last     = wide ? T1TX_WIDE_LAST : T1TX_T1_LAST;
    d = q;
    d.line_clk = i_line_clk;
    d.bp_clk   = i_bp_clk;

    // register port; unused bits are not stored and read zero
    if (i_wr) begin
      if (i_addr == T1TX_OFF_LINE) begin
        d.line_cfg = i_wdata;
      end else if (i_addr == T1TX_OFF_BP) begin
        d.bp_cfg = i_wdata[T1TX_BP_W-1:0];
      end else if (i_addr == T1TX_OFF_FRM) begin
        d.frm_cfg = i_wdata[T1TX_FRM_W-1:0];
      end
    end
    d.rdata = T1TX_UNUSED_RD;
    if (i_rd) begin
      if (i_addr == T1TX_OFF_LINE) begin
        d.rdata = q.line_cfg;
      end else if (i_addr == T1TX_OFF_BP) begin
        d.rdata = {3'h0, q.bp_cfg};
      end else if (i_addr == T1TX_OFF_FRM) begin
        d.rdata = {2'h0, q.frm_cfg};
      end
    end

    // fifo fill: dual rail feeds backplane rails straight in
    if (dual) begin
      wr_en   = bp_rise;
      wr_bits = {i_bp_pcm, i_bp_sig};
    end else begin
      wr_en   = i_enc_stb;
      wr_bits = {i_enc_pos, i_enc_neg};
    end
    // bypass skips the fifo; overrun drops the new bit
    if (bypass) begin
      src   = wr_bits;
      wr_en = 1'b0;
    end else begin
      src   = (q.count != '0) ? q.mem[q.rptr] : 2'h0;
      rd_en = upd && (q.count != '0);
    end
    if (wr_en && (q.count != T1TX_FULL)) begin
      d.mem[q.wptr] = wr_bits;
      d.wptr = q.wptr + 1'b1;
    end else begin
      wr_en = 1'b0;
    end
    if (rd_en) begin
      d.rptr = q.rptr + 1'b1;
    end
    if (wr_en && !rd_en) begin
      d.count = q.count + 1'b1;
    end else if (!wr_en && rd_en) begin
      d.count = q.count - 1'b1;
    end
    d.flag = q.line_cfg[T1TX_LB_FLAG_POL] ? (q.count >= T1TX_NEAR_FULL)
                                          : (q.count <= T1TX_NEAR_EMPTY);

    // line output at the update edge
    mark = src[1] | src[0];
    if (upd) begin
      // alarm changeover; leaving waits for a mark of correct polarity
      case (q.ais)
        T1TX_NORMAL: begin
          if (ais_en) begin
            d.ais    = T1TX_AIS;
            send_ais = 1'b1;
          end
        end
        T1TX_AIS: begin
          send_ais = 1'b1;
          if (!ais_en) begin
            d.ais = T1TX_EXIT;
          end
        end
        T1TX_EXIT: begin
          if (ais_en) begin
            d.ais    = T1TX_AIS;
            send_ais = 1'b1;
          end else if (mark && (src[0] != q.last_neg)) begin
            d.ais = T1TX_NORMAL;
          end else begin
            send_ais = 1'b1;
          end
        end
        default: begin
          d.ais = T1TX_NORMAL;
        end
      endcase
      if (uni) begin
        p_raw = send_ais | mark;
        n_raw = q.flag;
      end else if (send_ais) begin
        p_raw = q.last_neg;
        n_raw = ~q.last_neg;
      end else begin
        p_raw = src[1];
        n_raw = src[0];
      end
      if (!uni && (p_raw || n_raw)) begin
        d.last_neg = n_raw;
      end
      d.pos = p_raw ^ q.line_cfg[T1TX_LB_POS_INV];
      d.neg = n_raw ^ q.line_cfg[T1TX_LB_NEG_INV];
    end else if (clr && q.line_cfg[T1TX_LB_RZ] && !uni) begin
      // half-period pulse: return to the idle level
      d.pos = q.line_cfg[T1TX_LB_POS_INV];
      d.neg = q.line_cfg[T1TX_LB_NEG_INV];
    end
    d.analog_en = ~q.line_cfg[T1TX_LB_UNI];

    // framer clock source
    if (q.bp_cfg[T1TX_BB_REC_CLK]) begin
      d.framer_clk = i_rec_clk;
    end else begin
      d.framer_clk = i_bp_clk & ~(wide & q.filler);
    end

    // backplane bit position, frame and superframe tracking
    if (bp_rise) begin
      np = (q.bit_pos >= last) ? 9'h000 : q.bit_pos + 1'b1;
      if (q.bit_pos >= last) begin
        d.frame_idx = (q.frame_idx >= T1TX_SF_LAST) ? 5'h00
                                                    : q.frame_idx + 1'b1;
      end
      if (i_bp_frame_pulse) begin
        np = wide ? 9'h000 : T1TX_FBIT_POS;
        if (q.bp_cfg[T1TX_BB_SFP]) begin
          d.frame_idx = 5'h00;
        end
      end
      d.bit_pos   = np;
      d.fbit_slot = !wide && (np == T1TX_FBIT_POS);
      d.filler    = wide &&
          (np[T1TX_GRP_MSB:T1TX_BYTE_LSB] == T1TX_FILLER_BYTE);
      // framing insertion or passthrough
      if (d.fbit_slot && !q.frm_cfg[T1TX_FB_FRAMING_DISABLE] &&
          !fbit_pass(i_fbit_kind, q.frm_cfg)) begin
        d.framer_bit = i_gen_fbit;
      end else begin
        d.framer_bit = i_bp_pcm;
      end
      // signalling nibble format
      if (q.bp_cfg[T1TX_BB_TWO_BIT]) begin
        d.sig = {i_sig_nibble[3:2], i_sig_nibble[3:2]};
      end else begin
        d.sig = i_sig_nibble;
      end
    end

    // aligner placement is ignored while the aligner is off
    d.al_pre  = q.frm_cfg[T1TX_FB_AL_EN] & q.frm_cfg[T1TX_FB_AL_LOC];
    d.al_post = q.frm_cfg[T1TX_FB_AL_EN] & ~q.frm_cfg[T1TX_FB_AL_LOC];
  end

  //////////////////////////////////////////////////////////////////////////
  // state register; reset wins over the clock enable

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      q           <= '0;
      q.line_cfg  <= T1TX_LINE_RST;
      q.bp_cfg    <= T1TX_BP_RST;
      q.frm_cfg   <= T1TX_FRM_RST;
      q.ais       <= T1TX_NORMAL;
      q.analog_en <= 1'b1;
    end else if (i_ce) begin
      q <= d;
    end
  end

  assign o_rdata                = q.rdata;
  assign o_tx_pos               = q.pos;
  assign o_tx_neg               = q.neg;
  assign o_analog_enable        = q.analog_en;
  assign o_framer_clk           = q.framer_clk;
  assign o_framer_bit           = q.framer_bit;
  assign o_fbit_slot            = q.fbit_slot;
  assign o_filler_slot          = q.filler;
  assign o_frame_index          = q.frame_idx;
  assign o_sig_bits             = q.sig;
  assign o_aligner_pre_framer   = q.al_pre;
  assign o_aligner_post_extract = q.al_post;

  //////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  // reset checks must not be switched off by the default reset disable
  line_reset_a: assert property (disable iff (1'b0) i_rst |=>
      q.line_cfg == T1TX_LINE_RST && o_tx_pos == 1'b0 && o_tx_neg == 1'b0)
    else $error("line format register not cleared by reset");

  bp_reset_a: assert property (disable iff (1'b0)
      i_rst |=> q.bp_cfg == T1TX_BP_RST)
    else $error("backplane register not cleared by reset");

  bypass_hold_a: assert property (i_ce && bypass |=> $stable(q.rptr))
    else $error("fifo popped while bypassed");

  uni_ais_a: assert property (i_ce && upd && uni && ais_en &&
      !q.line_cfg[T1TX_LB_POS_INV] |=> o_tx_pos == 1'b1)
    else $error("unipolar alarm did not hold data at one");

  ais_alt_a: assert property (i_ce && upd && !uni &&
      q.ais == T1TX_AIS |=> q.last_neg != $past(q.last_neg))
    else $error("alarm pulses did not alternate");

  flag_out_a: assert property (i_ce && upd && uni |=>
      o_tx_neg == ($past(q.flag) ^ $past(q.line_cfg[T1TX_LB_NEG_INV])))
    else $error("fifo flag not driven on second pin");

  edge_hold_a: assert property (i_ce && !upd && !clr |=>
      $stable(o_tx_pos) && $stable(o_tx_neg))
    else $error("outputs changed off the update edge");

  rz_clear_a: assert property (i_ce && clr && !uni &&
      q.line_cfg[T1TX_LB_RZ] && !q.line_cfg[T1TX_LB_POS_INV] |=> !o_tx_pos)
    else $error("rz pulse did not return to zero");

  analog_off_a: assert property (i_ce && uni |=> !o_analog_enable)
    else $error("analog outputs left enabled in unipolar mode");

  sig_two_a: assert property (i_ce && bp_rise &&
      q.bp_cfg[T1TX_BB_TWO_BIT] |=> o_sig_bits[1:0] == o_sig_bits[3:2])
    else $error("two-bit signalling not duplicated");

  clk_rec_a: assert property (i_ce && q.bp_cfg[T1TX_BB_REC_CLK]
      |=> o_framer_clk == $past(i_rec_clk))
    else $error("framer clock not taken from recovered clock");

  framing_disable_pass_a: assert property (i_ce && bp_rise &&
      q.frm_cfg[T1TX_FB_FRAMING_DISABLE] |=> o_framer_bit == $past(i_bp_pcm))
    else $error("framing disable did not pass data");

  ais_enter_c: cover property (i_ce && upd && q.ais == T1TX_AIS);
  ais_exit_c: cover property (q.ais == T1TX_EXIT ##[1:50]
      q.ais == T1TX_NORMAL);
  fifo_fill_c: cover property (q.count == T1TX_NEAR_FULL);
  dual_rail_c: cover property (i_ce && dual && bp_rise);

endmodule

// ===== testbench/t1tx_far_end.sv
// far-end model: backplane system logic and line encoder feed
// assumes one i_clk; every clock made here is a divided level of it
`timescale 1ns/1ps

module t1tx_far_end
(
  input  wire logic i_clk,
  input  wire logic i_rst,
  input  wire logic i_wide,
  input  wire logic i_stb_en,
  input  wire logic i_mark_pos,
  input  wire logic i_mark_neg,
  output logic      o_line_clk,
  output logic      o_bp_clk,
  output logic      o_rec_clk,
  output logic      o_frame_pulse,
  output logic      o_pcm,
  output logic      o_sig,
  output logic      o_stb,
  output logic      o_pos,
  output logic      o_neg
);
  logic [2:0] div_q;
  logic [3:0] rdiv_q;
  logic [8:0] bit_q;
  logic [8:0] last;

  ////////////////////////////////////////////////////////////////////////////
  // frame length: 24 bytes plus framing bit, or 8 groups of 4 bytes
  assign last = i_wide ? 9'h0ff : 9'h0c0;

  // one divider for line and backplane so the two never drift apart;
  // data moves late in the high phase, far from the sampling rise
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      div_q         <= 3'h0;
      rdiv_q        <= 4'h0;
      bit_q         <= 9'h000;
      o_line_clk    <= 1'b0;
      o_bp_clk      <= 1'b0;
      o_rec_clk     <= 1'b0;
      o_frame_pulse <= 1'b0;
      o_pcm         <= 1'b0;
      o_sig         <= 1'b0;
      o_stb         <= 1'b0;
      o_pos         <= 1'b0;
      o_neg         <= 1'b0;
    end else begin
      div_q      <= div_q + 3'h1;
      rdiv_q     <= (rdiv_q == 4'hb) ? 4'h0 : rdiv_q + 4'h1;
      o_rec_clk  <= (rdiv_q < 4'h6);
      o_line_clk <= div_q[2];
      o_bp_clk   <= div_q[2];
      o_stb      <= i_stb_en && (div_q == 3'h3);
      o_pos      <= i_mark_pos;
      o_neg      <= i_mark_neg;
      if (div_q == 3'h7) begin
        bit_q         <= (bit_q == last) ? 9'h000 : bit_q + 9'h001;
        o_frame_pulse <= (bit_q == last);
        o_pcm         <= bit_q[0];
        o_sig         <= ~bit_q[1];
      end
    end
  end
endmodule

// ===== testbench/test_t1tx_iface.sv
// self-checking bench for the t1 transmit interface block
// assumes the far-end model supplies every line and backplane signal
`timescale 1ns/1ps

`define CHK(nm, got, exp) begin samples_checked++; \
  if ((got) !== (exp)) begin bad_count++; \
  $display("wrong value %s expected %h seen %h", nm, exp, got); end end

module test_t1tx_iface
  import t1tx_pkg::*;
;
  logic       clk, rst, wr, rd, wide, stb_en, mpos, mneg, sel, prev;
  logic [7:0] addr, wdata, rdata;
  logic       line_clk, bp_clk, rec_clk, fp, pcm, sig, stb, epos, eneg;
  logic       tx_pos, tx_neg, ana_en, fclk, fbit, fslot, filler, pre, post;
  logic [4:0] fidx, idx;
  logic [3:0] sbits;
  int         bad_count, samples_checked, cycles;
  wire        probe = sel ? filler : fslot;

  ////////////////////////////////////////////////////////////////////////////
  t1tx_iface uut (.i_clk(clk), .i_rst(rst), .i_ce(1'b1), .i_addr(addr),
    .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
    .i_line_clk(line_clk), .i_enc_stb(stb), .i_enc_pos(epos),
    .i_enc_neg(eneg), .i_bp_clk(bp_clk), .i_rec_clk(rec_clk),
    .i_bp_frame_pulse(fp), .i_bp_pcm(pcm), .i_bp_sig(sig),
    .i_sig_nibble(4'h9), .i_gen_fbit(1'b1), .i_fbit_kind(2'h0),
    .o_tx_pos(tx_pos), .o_tx_neg(tx_neg), .o_analog_enable(ana_en),
    .o_framer_clk(fclk), .o_framer_bit(fbit), .o_fbit_slot(fslot),
    .o_filler_slot(filler), .o_frame_index(fidx), .o_sig_bits(sbits),
    .o_aligner_pre_framer(pre), .o_aligner_post_extract(post));

  t1tx_far_end far (.i_clk(clk), .i_rst(rst), .i_wide(wide),
    .i_stb_en(stb_en), .i_mark_pos(mpos), .i_mark_neg(mneg),
    .o_line_clk(line_clk), .o_bp_clk(bp_clk), .o_rec_clk(rec_clk),
    .o_frame_pulse(fp), .o_pcm(pcm), .o_sig(sig), .o_stb(stb),
    .o_pos(epos), .o_neg(eneg));

  ////////////////////////////////////////////////////////////////////////////
  // register port: one-cycle strobes, read data in the following cycle
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    // read data stand only in the cycle after the strobe
    #1;
    `CHK("register read", rdata, exp)
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // count high cycles of the positive output over two line bits
  task automatic ones(input logic [7:0] cfg, input int exp);
    int n;
    wr_reg(8'h04, cfg);
    tick(40);
    n = 0;
    repeat (16) begin
      tick(1);
      n += (tx_pos === 1'b1);
    end
    `CHK("pulse width", n, exp)
  endtask

  // the framer clock trails its chosen source by one cycle
  task automatic follow(input logic [7:0] cfg);
    wr_reg(8'h05, cfg);
    tick(4);
    prev = cfg[3] ? rec_clk : bp_clk;
    repeat (24) begin
      tick(1);
      `CHK("framer clock", fclk, prev)
      prev = cfg[3] ? rec_clk : bp_clk;
    end
  endtask

  // bounded wait for the probed slot flag to reach a level
  task automatic wait_lvl(input logic lvl, output int n);
    n = 0;
    do begin
      tick(1);
      n++;
    end while (probe !== lvl && n < 4000);
  endtask

  // wait for the start of the next probed slot
  task automatic at_slot();
    int n;
    wait_lvl(1'b0, n);
    wait_lvl(1'b1, n);
  endtask

  // line clock level seen when the alarm output next toggles
  task automatic upd_edge(input logic [7:0] cfg, input logic lvl);
    logic p;
    wr_reg(8'h04, cfg);
    tick(40);
    p = tx_pos;
    repeat (8) if (tx_pos === p) tick(1);
    `CHK("update edge", line_clk, lvl)
  endtask

  // width and repeat period of a slot flag, in system clock cycles
  task automatic span(input logic [7:0] cfg, input logic w, input int hi_exp,
                      input int per_exp);
    int a, hi, lo;
    wide <= w;
    sel  <= w;
    wr_reg(8'h05, cfg);
    tick(2100);
    wait_lvl(1'b0, a);
    wait_lvl(1'b1, a);
    wait_lvl(1'b0, hi);
    wait_lvl(1'b1, lo);
    `CHK("slot width", hi, hi_exp)
    `CHK("slot period", hi + lo, per_exp)
  endtask

  task automatic complete_run();
    if (bad_count == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  always #4 clk = ~clk;

  // a hang ends the run as a mismatch
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      bad_count++;
      complete_run();
    end
  end

  // main sequence: registers, line stage, then backplane timing
  initial begin
    clk = 0; rst = 1; wr = 0; rd = 0; addr = 8'h00; wdata = 8'h00;
    wide = 0; sel = 0; stb_en = 1; mpos = 1; mneg = 0; prev = 0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    rd_reg(8'h04, 8'h00);
    `CHK("analog enable", ana_en, 1'b1)
    rd_reg(8'h05, 8'h00);
    rd_reg(8'h06, 8'h00);
    wr_reg(8'h05, 8'hfa);
    rd_reg(8'h05, 8'h1a);
    wr_reg(8'h06, 8'hff);
    rd_reg(8'h06, 8'h3f);
    `CHK("aligner before framer", {pre, post}, 2'h2)
    wr_reg(8'h06, 8'h20);
    tick(2);
    `CHK("aligner after extractor", {pre, post}, 2'h1)
    wr_reg(8'h06, 8'h10);
    tick(2);
    `CHK("aligner disabled", {pre, post}, 2'h0)
    wr_reg(8'h07, 8'h5a);
    rd_reg(8'h07, 8'h00);
    wr_reg(8'h04, 8'ha5);
    rd_reg(8'h04, 8'ha5);
    wr_reg(8'h05, 8'h00);
    wr_reg(8'h06, 8'h00);
    ones(8'h80, 16);
    ones(8'h81, 8);
    ones(8'h90, 0);
    wr_reg(8'h04, 8'ha0);
    tick(40);
    `CHK("negative invert", {tx_pos, tx_neg}, 2'h3)
    wr_reg(8'h04, 8'hc0);
    tick(40);
    prev = tx_pos;
    repeat (6) begin
      tick(8);
      `CHK("alarm marks", {tx_pos, tx_neg}, {~prev, prev})
      prev = tx_pos;
    end
    upd_edge(8'hc2, 1'b1);
    upd_edge(8'hc0, 1'b0);
    wr_reg(8'h04, 8'h48);
    tick(40);
    `CHK("unipolar alarm", tx_pos, 1'b1)
    `CHK("analog enable", ana_en, 1'b0)
    stb_en <= 1'b0;
    wr_reg(8'h04, 8'h08);
    tick(600);
    `CHK("near empty flag", tx_neg, 1'b1)
    wr_reg(8'h04, 8'h0c);
    tick(20);
    `CHK("near full flag", tx_neg, 1'b0)
    wr_reg(8'h04, 8'h2c);
    tick(20);
    `CHK("inverted flag", tx_neg, 1'b1)
    stb_en <= 1'b1;
    wr_reg(8'h04, 8'h00);
    follow(8'h08);
    follow(8'h00);
    span(8'h00, 1'b0, 8, 1544);
    // framing slot contents, one frame apart
    wr_reg(8'h05, 8'h10);
    at_slot();
    idx = fidx;
    `CHK("two-bit signalling", sbits, 4'ha)
    `CHK("generated framing bit", fbit, 1'b1)
    wr_reg(8'h05, 8'h00);
    wr_reg(8'h06, 8'h04);
    at_slot();
    `CHK("four-bit signalling", sbits, 4'h9)
    `CHK("passed framing bit", fbit, 1'b0)
    `CHK("frame index", fidx, (idx == T1TX_SF_LAST) ? 5'h00 : idx + 5'h01)
    wr_reg(8'h06, 8'h08);
    at_slot();
    `CHK("framing disabled", fbit, 1'b0)
    wr_reg(8'h06, 8'h00);
    span(8'h04, 1'b1, 64, 256);
    complete_run();
  end
endmodule
